// [hw/rps_pkg.sv]
// Package with register map, field layout and carrier types of the remap output selector
package rps_pkg;
  localparam int SEL_W = 6;
  localparam int REG_W = 16;
  localparam logic [11:0] OFS_SELECT_6 = 12'h000;
  localparam logic [11:0] OFS_SELECT_7 = 12'h004;
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
  localparam int NUM_PINS = 4;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rps_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rps_apb_rsp_t;

  typedef struct packed {
    logic [SEL_W-1:0] sel12;
    logic [SEL_W-1:0] sel13;
    logic [SEL_W-1:0] sel14;
    logic [SEL_W-1:0] sel15;
  } rps_state_t;
endpackage : rps_pkg

// [hw/rps_pin_mux.sv]
// One remappable output pin: selects a peripheral output by number
`timescale 1ns/10ps
module rps_pin_mux
  import rps_pkg::*;
#(
  parameter int NUM_PERIPH = 64
) (
  // Selection
  input wire logic [SEL_W-1:0] sel,
  input wire logic [NUM_PERIPH-1:0] periph_out,
  input wire logic port_out,
  // Pin drive
  output logic pin_out,
  output logic pin_mapped
);
  // Zero selects nothing, so the pin falls back to the port latch
  always_comb begin
    pin_mapped = (sel != SEL_NONE);
    pin_out = pin_mapped ? periph_out[sel] : port_out;
  end
endmodule : rps_pin_mux

// [hw/rps_top.sv]
// Top of the remappable output pin selector with its APB register slave
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module rps_top
  import rps_pkg::*;
#(
  parameter int NUM_PERIPH = 64,
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Peripheral outputs and port latches
  input wire logic [NUM_PERIPH-1:0] PERIPH_OUT,
  input wire logic [NUM_PINS-1:0] PORT_OUT,
  // Remappable pins 12 to 15, bit 0 is pin 12
  output logic [NUM_PINS-1:0] REMAP_PIN_OUT,
  output logic [NUM_PINS-1:0] REMAP_PIN_MAPPED
);
  rps_apb_req_t req;
  rps_apb_rsp_t rsp;
  rps_state_t state_q;
  rps_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;
  logic rd_en;
  logic hit6;
  logic hit7;
  logic [SEL_W-1:0] sel_lo;
  logic [SEL_W-1:0] sel_hi;
  logic [SEL_W-1:0] sel_vec [NUM_PINS];
  logic [31:0] word6;
  logic [31:0] word7;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  // Zero-wait slave: every access completes in its first access cycle
  always_comb begin
    hit6 = (req.paddr == OFS_SELECT_6);
    hit7 = (req.paddr == OFS_SELECT_7);
    wr_en = req.psel && req.penable && req.pwrite;
    rd_en = req.psel && !req.penable && !req.pwrite;
    sel_lo = req.pwdata[LO_FIELD_LSB +: SEL_W];
    sel_hi = req.pwdata[HI_FIELD_LSB +: SEL_W];
  end

  // Reserved bits are tied off here so every read path sees zeros
  always_comb begin
    word6 = 32'h0000_0000;
    word7 = 32'h0000_0000;
    word6[LO_FIELD_LSB +: SEL_W] = state_q.sel12;
    word6[HI_FIELD_LSB +: SEL_W] = state_q.sel13;
    word7[LO_FIELD_LSB +: SEL_W] = state_q.sel14;
    word7[HI_FIELD_LSB +: SEL_W] = state_q.sel15;
  end

  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    if (wr_en && hit6) begin
      state_d.sel12 = sel_lo;
      state_d.sel13 = sel_hi;
    end
    if (wr_en && hit7) begin
      state_d.sel14 = sel_lo;
      state_d.sel15 = SMALL_PACKAGE ? SEL_NONE : sel_hi;
    end
    // Read data is captured in setup so it comes from a flop in the access cycle
    // Unmapped reads clear the word so stale data never leaks out
    if (rd_en) begin
      if (hit6) begin
        rdata_d = word6;
      end else if (hit7) begin
        rdata_d = word7;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= '{default: SEL_RESET};
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
    end
  end

  // Unmapped addresses read zero and report an error, writes there are dropped
  always_comb begin
    rsp.prdata = rdata_q;
    rsp.pready = 1'b1;
    rsp.pslverr = req.psel && req.penable && !(hit6 || hit7);
  end
  assign PRDATA = rsp.prdata;
  assign PREADY = rsp.pready;
  assign PSLVERR = rsp.pslverr;

  assign sel_vec[0] = state_q.sel12;
  assign sel_vec[1] = state_q.sel13;
  assign sel_vec[2] = state_q.sel14;
  assign sel_vec[3] = state_q.sel15;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    rps_pin_mux #(.NUM_PERIPH(NUM_PERIPH)) u_mux (
      .sel(sel_vec[i]),
      .periph_out(PERIPH_OUT),
      .port_out(PORT_OUT[i]),
      .pin_out(REMAP_PIN_OUT[i]),
      .pin_mapped(REMAP_PIN_MAPPED[i])
    );
  end

  // Checks
  a_write_sel12: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && hit6) |=> state_q.sel12 == $past(PWDATA[5:0]))
    else $error("pin 12 selector not loaded");
  a_write_sel13: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && hit6) |=> state_q.sel13 == $past(PWDATA[13:8]))
    else $error("pin 13 selector not loaded");
  a_write_sel14: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && hit7) |=> state_q.sel14 == $past(PWDATA[5:0]))
    else $error("pin 14 selector not loaded");
  a_write_sel15: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && hit7 && !SMALL_PACKAGE) |=> state_q.sel15 == $past(PWDATA[13:8]))
    else $error("pin 15 selector not loaded");
  a_small_pkg_zero: assert property (@(posedge CLOCK) disable iff (RST)
    SMALL_PACKAGE |-> state_q.sel15 == 6'h00)
    else $error("pin 15 selector present on small package");
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (RST)
    PRDATA[31:14] == 18'h00000 && PRDATA[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  a_small_drop: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && hit7 && SMALL_PACKAGE) |=> state_q.sel15 == 6'h00)
    else $error("pin 15 selector loaded on small package");

  // Routing of every pin, port fallback of pins 12 and 15, mapped flag of pin 12
  a_route_pin12: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel12 != 6'h00) |-> REMAP_PIN_OUT[0] == PERIPH_OUT[state_q.sel12])
    else $error("pin 12 not routed");
  a_route_pin13: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel13 != 6'h00) |-> REMAP_PIN_OUT[1] == PERIPH_OUT[state_q.sel13])
    else $error("pin 13 not routed");
  a_route_pin14: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel14 != 6'h00) |-> REMAP_PIN_OUT[2] == PERIPH_OUT[state_q.sel14])
    else $error("pin 14 not routed");
  a_route_pin15: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel15 != 6'h00) |-> REMAP_PIN_OUT[3] == PERIPH_OUT[state_q.sel15])
    else $error("pin 15 not routed");
  a_port_pin12: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel12 == 6'h00) |-> REMAP_PIN_OUT[0] == PORT_OUT[0])
    else $error("pin 12 not on port control");
  a_port_pin15: assert property (@(posedge CLOCK) disable iff (RST)
    (state_q.sel15 == 6'h00) |-> REMAP_PIN_OUT[3] == PORT_OUT[3])
    else $error("pin 15 not on port control");
  a_mapped_flag: assert property (@(posedge CLOCK) disable iff (RST)
    REMAP_PIN_MAPPED[0] == (state_q.sel12 != 6'h00))
    else $error("pin 12 mapped flag wrong");

  // First edge after reset release sees cleared selectors
  a_idle_port: assert property (@(posedge CLOCK)
    ($past(RST) && !RST) |-> state_q == '0 && REMAP_PIN_OUT == PORT_OUT)
    else $error("pins not on port control after reset");
  a_hold_idle: assert property (@(posedge CLOCK) disable iff (RST)
    !wr_en |=> $stable(state_q))
    else $error("selector changed without a write");

  // Bus side
  a_ready_high: assert property (@(posedge CLOCK) disable iff (RST)
    PREADY)
    else $error("ready dropped");
  a_unmapped_err: assert property (@(posedge CLOCK) disable iff (RST)
    (PSEL && PENABLE && PADDR != OFS_SELECT_6 && PADDR != OFS_SELECT_7) |-> PSLVERR)
    else $error("unmapped access not flagged");
  a_unmapped_drop: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_en && !hit6 && !hit7) |=> $stable(state_q))
    else $error("unmapped write changed a selector");
  a_rdata_hold: assert property (@(posedge CLOCK) disable iff (RST)
    !rd_en |=> $stable(PRDATA))
    else $error("read data moved outside a read");
  a_readback_7: assert property (@(posedge CLOCK) disable iff (RST)
    (rd_en && hit7) |=> PRDATA[13:0] == {2'h0, state_q.sel15, 2'h0, state_q.sel14})
    else $error("readback mismatch on second register");
  a_readback_6: assert property (@(posedge CLOCK) disable iff (RST)
    (rd_en && hit6) |=> PRDATA[13:0] == {2'h0, state_q.sel13, 2'h0, state_q.sel12})
    else $error("readback mismatch");

  c_write6: cover property (@(posedge CLOCK) wr_en && hit6);
  c_write7: cover property (@(posedge CLOCK) wr_en && hit7);
  c_read7: cover property (@(posedge CLOCK) rd_en && hit7);
  c_mapped: cover property (@(posedge CLOCK) REMAP_PIN_MAPPED == 4'hF);
  c_unmapped: cover property (@(posedge CLOCK) rsp.pslverr);
endmodule : rps_top

// [dv/rps_top_bench.sv]
// Self-checking bench of the remap output selector, with a small-package twin
`timescale 1ns/10ps
module rps_top_bench;
  import rps_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rdy, err, e0;
  logic [11:0] pa = 0;
  logic [31:0] pw = 0, rd, rd_s, r0, r1;
  logic [63:0] po = 0;
  logic [3:0] pt = 0, pin, map, pin_s;
  logic [5:0] sel[4];
  int bad_count = 0, num_checks = 0;
  rps_top u_dut (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pw), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .PERIPH_OUT(po), .PORT_OUT(pt),
    .REMAP_PIN_OUT(pin), .REMAP_PIN_MAPPED(map));
  // Twin shares every input, so one write sequence exercises both packages
  rps_top #(.SMALL_PACKAGE(1'b1)) u_small (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(rd_s), .PREADY(), .PSLVERR(), .PERIPH_OUT(po),
    .PORT_OUT(pt), .REMAP_PIN_OUT(pin_s), .REMAP_PIN_MAPPED());
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // Request holds until ready is seen high at a rising edge; the answer is taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    r0 = rd;
    r1 = rd_s;
    e0 = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic logic [31:0] ex(input int r, input bit sm);
    logic [31:0] v;
    v = 32'h0;
    v[5:0] = sel[2*r];
    v[13:8] = (sm && r == 1) ? 6'h00 : sel[2*r+1];
    return v;
  endfunction : ex
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #50us;
    bad_count++;
    wrap_up();
  end
  initial begin
    int r;
    logic [31:0] d;
    void'($urandom(32'hF15D));
    sel = '{default: 6'h00};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r0, ex(i, 0));
    end
    $display("reset test done");
    // All ones and all zeros first, then random words with reserved bits set
    for (int k = 0; k < 40; k++) begin
      r = (k < 4) ? k % 2 : $urandom_range(1);
      d = (k < 2) ? 32'hFFFFFFFF : (k < 4) ? 32'h0 : $urandom;
      po <= {$urandom, $urandom};
      pt <= 4'($urandom);
      apb(1'b1, 12'(r * 4), d);
      chk(e0, 1'b0);
      sel[2*r] = d[5:0];
      sel[2*r+1] = d[13:8];
      apb(1'b0, 12'(r * 4), 32'h0);
      chk(r0, ex(r, 0));
      chk(r1, ex(r, 1));
      @(negedge clk);
      for (int p = 0; p < 4; p++) begin
        chk(pin[p], (sel[p] != 0) ? po[sel[p]] : pt[p]);
        chk(map[p], sel[p] != 0);
      end
      chk(pin_s[3], pt[3]);
      @(posedge clk);
    end
    $display("select test done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    sel = '{default: 6'h00};
    @(posedge clk);
    @(negedge clk);
    for (int p = 0; p < 4; p++) begin
      chk(pin[p], pt[p]);
      chk(map[p], 1'b0);
    end
    @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r0, ex(i, 0));
    end
    $display("mid reset test done");
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk(e0, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(r0, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r0, ex(i, 0));
    end
    $display("unmapped test done");
    wrap_up();
  end
endmodule : rps_top_bench
